// [verilog/lcplru_top.sv]
// l1 instruction and data cache pseudo-lru replacement state
`timescale 1ns/10ps
module lcplru_top (
    // clock and reset
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    // control bits of hardware_impl_config0
    input wire logic DCACHE_FLUSH_ASSIST_I,
    input wire logic DCACHE_FLASH_INVALIDATE_I,
    input wire logic ICACHE_FLASH_INVALIDATE_I,
    // data cache hit
    input wire logic D_HIT_I,
    input wire logic [lcplru_pkg::SET_W-1:0] D_HIT_SET_I,
    input wire logic [lcplru_pkg::WAY_W-1:0] D_HIT_WAY_I,
    input wire logic D_HIT_LRU_I,
    // data cache reload
    input wire logic D_RELOAD_I,
    input wire logic [lcplru_pkg::SET_W-1:0] D_RELOAD_SET_I,
    input wire logic D_RELOAD_LRU_I,
    output logic [lcplru_pkg::WAY_W-1:0] D_RELOAD_WAY_O,
    // data cache block invalidate
    input wire logic D_INVAL_I,
    input wire logic [lcplru_pkg::SET_W-1:0] D_INVAL_SET_I,
    input wire logic [lcplru_pkg::WAY_W-1:0] D_INVAL_WAY_I,
    // instruction cache miss
    input wire logic I_MISS_I,
    input wire logic [lcplru_pkg::SET_W-1:0] I_MISS_SET_I,
    output logic [lcplru_pkg::WAY_W-1:0] I_MISS_WAY_O,
    // instruction cache hit
    input wire logic I_HIT_I,
    input wire logic [lcplru_pkg::SET_W-1:0] I_HIT_SET_I,
    input wire logic [lcplru_pkg::WAY_W-1:0] I_HIT_WAY_I,
    // instruction cache reload into latched victim
    input wire logic I_RELOAD_I,
    input wire logic [lcplru_pkg::SET_W-1:0] I_RELOAD_SET_I,
    // instruction cache block invalidate
    input wire logic I_INVAL_I,
    input wire logic [lcplru_pkg::SET_W-1:0] I_INVAL_SET_I,
    input wire logic [lcplru_pkg::WAY_W-1:0] I_INVAL_WAY_I,
    // observation
    input wire logic [lcplru_pkg::SET_W-1:0] OBS_SET_I,
    output logic [lcplru_pkg::WAYS-1:0] D_OBS_VALID_O,
    output logic [lcplru_pkg::TREE_W-1:0] D_OBS_TREE_O,
    output logic [lcplru_pkg::WAYS-1:0] I_OBS_VALID_O,
    output logic [lcplru_pkg::TREE_W-1:0] I_OBS_TREE_O
);
    import lcplru_pkg::*;

    // reset release
    logic [SYNC_STAGES-1:0] rst_sync_r;
    logic rst_n;
    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rst_sync_r <= '0;
        end else begin
            rst_sync_r <= {rst_sync_r[SYNC_STAGES-2:0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[SYNC_STAGES-1];

    // per-set state arrays
    logic [WAYS-1:0] d_valid_r [SETS];
    logic [TREE_W-1:0] d_tree_r [SETS];
    logic [WAYS-1:0] i_valid_r [SETS];
    logic [TREE_W-1:0] i_tree_r [SETS];
    logic [WAY_W-1:0] i_victim_r;

    // data victim from current reload set
    logic [WAY_W-1:0] d_victim;
    lcplru_victim u_d_victim (
        .valid_i(d_valid_r[D_RELOAD_SET_I]),
        .tree_i(d_tree_r[D_RELOAD_SET_I]),
        .ignore_invalid_i(DCACHE_FLUSH_ASSIST_I),
        .way_o(d_victim)
    );
    assign D_RELOAD_WAY_O = d_victim;

    // instruction victim at miss
    logic [WAY_W-1:0] i_victim;
    lcplru_victim u_i_victim (
        .valid_i(i_valid_r[I_MISS_SET_I]),
        .tree_i(i_tree_r[I_MISS_SET_I]),
        .ignore_invalid_i(1'b0),
        .way_o(i_victim)
    );
    assign I_MISS_WAY_O = i_victim;

    // data tree updates: hit first, then reload
    logic [TREE_W-1:0] d_hit_tree;
    logic [TREE_W-1:0] d_rl_base;
    logic [TREE_W-1:0] d_rl_tree;
    lcplru_update u_d_hit (
        .tree_i(d_tree_r[D_HIT_SET_I]),
        .way_i(D_HIT_WAY_I),
        .lru_i(D_HIT_LRU_I),
        .tree_o(d_hit_tree)
    );
    assign d_rl_base = (D_HIT_I && D_HIT_SET_I == D_RELOAD_SET_I) ? d_hit_tree
                       : d_tree_r[D_RELOAD_SET_I];
    lcplru_update u_d_rl (
        .tree_i(d_rl_base),
        .way_i(d_victim),
        .lru_i(D_RELOAD_LRU_I),
        .tree_o(d_rl_tree)
    );

    // instruction tree updates, never lru
    logic [TREE_W-1:0] i_hit_tree;
    logic [TREE_W-1:0] i_rl_base;
    logic [TREE_W-1:0] i_rl_tree;
    lcplru_update u_i_hit (
        .tree_i(i_tree_r[I_HIT_SET_I]),
        .way_i(I_HIT_WAY_I),
        .lru_i(1'b0),
        .tree_o(i_hit_tree)
    );
    assign i_rl_base = (I_HIT_I && I_HIT_SET_I == I_RELOAD_SET_I) ? i_hit_tree
                       : i_tree_r[I_RELOAD_SET_I];
    lcplru_update u_i_rl (
        .tree_i(i_rl_base),
        .way_i(i_victim_r),
        .lru_i(1'b0),
        .tree_o(i_rl_tree)
    );

    // latched instruction victim
    always_ff @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
            i_victim_r <= 3'h0;
        end else if (I_MISS_I) begin
            i_victim_r <= i_victim;
        end
    end

    // per-set state update
    genvar s;
    generate
        for (s = 0; s < SETS; s++) begin : g_set
            always_ff @(posedge MCLK_I or negedge rst_n) begin
                if (!rst_n) begin
                    d_valid_r[s] <= VALID_RESET;
                    d_tree_r[s] <= TREE_RESET;
                end else if (DCACHE_FLASH_INVALIDATE_I) begin
                    d_valid_r[s] <= VALID_RESET;
                    d_tree_r[s] <= TREE_RESET;
                end else begin
                    if (D_RELOAD_I && D_RELOAD_SET_I == s) begin
                        d_tree_r[s] <= d_rl_tree;
                    end else if (D_HIT_I && D_HIT_SET_I == s) begin
                        d_tree_r[s] <= d_hit_tree;
                    end
                    if (D_RELOAD_I && D_RELOAD_SET_I == s) begin
                        d_valid_r[s][d_victim] <= 1'b1;
                    end else if (D_INVAL_I && D_INVAL_SET_I == s) begin
                        d_valid_r[s][D_INVAL_WAY_I] <= 1'b0;
                    end
                end
            end
            always_ff @(posedge MCLK_I or negedge rst_n) begin
                if (!rst_n) begin
                    i_valid_r[s] <= VALID_RESET;
                    i_tree_r[s] <= TREE_RESET;
                end else if (ICACHE_FLASH_INVALIDATE_I) begin
                    i_valid_r[s] <= VALID_RESET;
                    i_tree_r[s] <= TREE_RESET;
                end else begin
                    if (I_RELOAD_I && I_RELOAD_SET_I == s) begin
                        i_tree_r[s] <= i_rl_tree;
                    end else if (I_HIT_I && I_HIT_SET_I == s) begin
                        i_tree_r[s] <= i_hit_tree;
                    end
                    if (I_RELOAD_I && I_RELOAD_SET_I == s) begin
                        i_valid_r[s][i_victim_r] <= 1'b1;
                    end else if (I_INVAL_I && I_INVAL_SET_I == s) begin
                        i_valid_r[s][I_INVAL_WAY_I] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // observation registers
    always_ff @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
            D_OBS_VALID_O <= VALID_RESET;
            D_OBS_TREE_O <= TREE_RESET;
            I_OBS_VALID_O <= VALID_RESET;
            I_OBS_TREE_O <= TREE_RESET;
        end else begin
            D_OBS_VALID_O <= d_valid_r[OBS_SET_I];
            D_OBS_TREE_O <= d_tree_r[OBS_SET_I];
            I_OBS_VALID_O <= i_valid_r[OBS_SET_I];
            I_OBS_TREE_O <= i_tree_r[OBS_SET_I];
        end
    end
endmodule // lcplru_top

// [verilog/lcplru_pkg.sv]
// package with constants for the l1 replacement block
package lcplru_pkg;
    localparam int SETS = 128;
    localparam int WAYS = 8;
    localparam int SET_W = 7;
    localparam int WAY_W = 3;
    localparam int TREE_W = 7;
    localparam logic [TREE_W-1:0] TREE_RESET = 7'h00;
    localparam logic [WAYS-1:0] VALID_RESET = 8'h00;
    localparam int SYNC_STAGES = 2;
endpackage

// [verilog/lcplru_victim.sv]
// victim way selection from valid bits and tree bits
`timescale 1ns/10ps
module lcplru_victim (
    // set state
    input wire logic [lcplru_pkg::WAYS-1:0] valid_i,
    input wire logic [lcplru_pkg::TREE_W-1:0] tree_i,
    // mode
    input wire logic ignore_invalid_i,
    // result
    output logic [lcplru_pkg::WAY_W-1:0] way_o
);
    import lcplru_pkg::*;
    logic [WAY_W-1:0] first_inv;
    logic any_inv;
    logic [WAY_W-1:0] tree_way;
    always_comb begin
        first_inv = 3'h0;
        any_inv = 1'b0;
        for (int i = WAYS - 1; i >= 0; i--) begin
            if (!valid_i[i]) begin
                first_inv = i[WAY_W-1:0];
                any_inv = 1'b1;
            end
        end
    end
    always_comb begin
        if (!tree_i[0]) begin
            if (!tree_i[1]) begin
                tree_way = tree_i[3] ? 3'h1 : 3'h0;
            end else begin
                tree_way = tree_i[4] ? 3'h3 : 3'h2;
            end
        end else begin
            if (!tree_i[2]) begin
                tree_way = tree_i[5] ? 3'h5 : 3'h4;
            end else begin
                tree_way = tree_i[6] ? 3'h7 : 3'h6;
            end
        end
    end
    assign way_o = (any_inv && !ignore_invalid_i) ? first_inv : tree_way;
endmodule // lcplru_victim

// [verilog/lcplru_update.sv]
// tree bit update for one access
`timescale 1ns/10ps
module lcplru_update (
    // inputs
    input wire logic [lcplru_pkg::TREE_W-1:0] tree_i,
    input wire logic [lcplru_pkg::WAY_W-1:0] way_i,
    input wire logic lru_i,
    // result
    output logic [lcplru_pkg::TREE_W-1:0] tree_o
);
    import lcplru_pkg::*;
    logic inv;
    always_comb begin
        inv = lru_i;
        tree_o = tree_i;
        tree_o[0] = ~way_i[2] ^ inv;
        if (!way_i[2]) begin
            tree_o[1] = ~way_i[1] ^ inv;
            if (!way_i[1]) begin
                tree_o[3] = ~way_i[0] ^ inv;
            end else begin
                tree_o[4] = ~way_i[0] ^ inv;
            end
        end else begin
            tree_o[2] = ~way_i[1] ^ inv;
            if (!way_i[1]) begin
                tree_o[5] = ~way_i[0] ^ inv;
            end else begin
                tree_o[6] = ~way_i[0] ^ inv;
            end
        end
    end
endmodule // lcplru_update

// [verif/lcplru_chk.sv]
// assertions on the ports of the l1 replacement block
`timescale 1ns/10ps
module lcplru_chk import lcplru_pkg::*; (
    input wire logic MCLK_I, RESETN_I, DCACHE_FLUSH_ASSIST_I,
    input wire logic DCACHE_FLASH_INVALIDATE_I, ICACHE_FLASH_INVALIDATE_I,
    input wire logic D_HIT_I, D_RELOAD_I, D_INVAL_I, I_HIT_I, I_RELOAD_I, I_INVAL_I,
    input wire logic [SET_W-1:0] D_RELOAD_SET_I, I_MISS_SET_I, OBS_SET_I,
    input wire logic [WAY_W-1:0] D_RELOAD_WAY_O, I_MISS_WAY_O,
    input wire logic [WAYS-1:0] D_OBS_VALID_O, I_OBS_VALID_O,
    input wire logic [TREE_W-1:0] D_OBS_TREE_O, I_OBS_TREE_O
);
    logic [SET_W-1:0] os_r;
    logic dq_r, iq_r;
    wire dq = dq_r && os_r == D_RELOAD_SET_I;
    wire iq = iq_r && os_r == I_MISS_SET_I;
    function automatic logic [2:0] dec(logic [6:0] t);
        dec[2] = t[0];
        dec[1] = t[1 + dec[2]];
        dec[0] = t[3 + dec[2:1]];
    endfunction
    function automatic bit low(logic [7:0] v, logic [2:0] w);
        return (~{1'b1, v} & ((9'h002 << w) - 9'h001)) == (9'h001 << w);
    endfunction
    // quiet flags: no state change in the cycle the obs outputs show
    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            os_r <= 7'h00;
            dq_r <= 1'b0;
            iq_r <= 1'b0;
        end else begin
            os_r <= OBS_SET_I;
            dq_r <= !(D_HIT_I | D_RELOAD_I | D_INVAL_I | DCACHE_FLASH_INVALIDATE_I);
            iq_r <= !(I_HIT_I | I_RELOAD_I | I_INVAL_I | ICACHE_FLASH_INVALIDATE_I);
        end
    end
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RESETN_I);
    a_reset_state: assert property ($rose(RESETN_I) |-> D_OBS_VALID_O == 8'h00
        && D_OBS_TREE_O == 7'h00 && I_OBS_VALID_O == 8'h00 && I_OBS_TREE_O == 7'h00)
        else $error("state not clear after reset");
    a_dflash_clear: assert property (DCACHE_FLASH_INVALIDATE_I |-> ##2
        (D_OBS_VALID_O == 8'h00 && D_OBS_TREE_O == 7'h00)) else $error("data flash");
    a_iflash_clear: assert property (ICACHE_FLASH_INVALIDATE_I |-> ##2
        (I_OBS_VALID_O == 8'h00 && I_OBS_TREE_O == 7'h00)) else $error("instr flash");
    a_dvic_low: assert property (dq && !DCACHE_FLUSH_ASSIST_I && D_OBS_VALID_O != 8'hff
        |-> low(D_OBS_VALID_O, D_RELOAD_WAY_O)) else $error("data victim not low");
    a_dvic_tree: assert property (dq && D_OBS_VALID_O == 8'hff
        |-> D_RELOAD_WAY_O == dec(D_OBS_TREE_O)) else $error("data victim tree");
    a_dassist_tree: assert property (dq && DCACHE_FLUSH_ASSIST_I
        |-> D_RELOAD_WAY_O == dec(D_OBS_TREE_O)) else $error("assist victim");
    a_ivic_low: assert property (iq && I_OBS_VALID_O != 8'hff
        |-> low(I_OBS_VALID_O, I_MISS_WAY_O)) else $error("instr victim not low");
    a_ivic_tree: assert property (iq && I_OBS_VALID_O == 8'hff
        |-> I_MISS_WAY_O == dec(I_OBS_TREE_O)) else $error("instr victim tree");
endmodule // lcplru_chk
bind lcplru_top lcplru_chk i_lcplru_chk (.*);

// [verif/lcplru_core_model.sv]
// core side model running an assisted flush of one data cache set
`timescale 1ns/10ps
module lcplru_core_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic go_i,
    input wire logic [6:0] set_i,
    output logic assist_o,
    output logic reload_o,
    output logic [6:0] set_o
);
    int n;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            n <= 0;
            assist_o <= 1'b0;
            reload_o <= 1'b0;
            set_o <= 7'h00;
        end else if (n == 0) begin
            if (go_i) begin
                n <= 1;
                assist_o <= 1'b1;
                set_o <= set_i;
            end
        end else if (n <= 8) begin
            reload_o <= 1'b1;
            n <= n + 1;
        end else begin
            reload_o <= 1'b0;
            assist_o <= 1'b0;
            n <= 0;
        end
    end
endmodule // lcplru_core_model

// [verif/lcplru_top_bench.sv]
// random self-checking bench for the l1 replacement block
`timescale 1ns/10ps
module lcplru_top_bench;
    logic clk = 1'b0, rst_n = 1'b0, dfi = 0, ifi = 0, dh = 0, dhl = 0, drl = 0, drll = 0;
    logic dv = 0, im = 0, ih = 0, irl = 0, iv = 0, go = 0, p_as, p_rl;
    logic [6:0] dhs = 0, drs = 0, dvs = 0, ims = 0, ihs = 0, irs = 0, ivs = 0, os = 0, gs = 0;
    logic [6:0] p_st, dto, ito;
    logic [2:0] dhw = 0, dvw = 0, ihw = 0, ivw = 0, ilw = 0, dwo, iwo;
    logic [7:0] dvo, ivo;
    logic [7:0] mv[2][128];
    logic [6:0] mt[2][128];
    logic [29:0] eo = 0;
    logic [31:0] r, q;
    int error_cnt = 0, checks_done = 0;
    wire rl = drl | p_rl;
    wire [6:0] rs = p_as ? p_st : drs;
    always #20 clk = ~clk;
    lcplru_core_model i_lcplru_core_model (.clk_i(clk), .rst_n_i(rst_n), .go_i(go),
        .set_i(gs), .assist_o(p_as), .reload_o(p_rl), .set_o(p_st));
    lcplru_top i_lcplru_top (.MCLK_I(clk), .RESETN_I(rst_n), .DCACHE_FLUSH_ASSIST_I(p_as),
        .DCACHE_FLASH_INVALIDATE_I(dfi), .ICACHE_FLASH_INVALIDATE_I(ifi), .D_HIT_I(dh),
        .D_HIT_SET_I(dhs), .D_HIT_WAY_I(dhw), .D_HIT_LRU_I(dhl), .D_RELOAD_I(rl),
        .D_RELOAD_SET_I(rs), .D_RELOAD_LRU_I(drll), .D_RELOAD_WAY_O(dwo), .D_INVAL_I(dv),
        .D_INVAL_SET_I(dvs), .D_INVAL_WAY_I(dvw), .I_MISS_I(im), .I_MISS_SET_I(ims),
        .I_MISS_WAY_O(iwo), .I_HIT_I(ih), .I_HIT_SET_I(ihs), .I_HIT_WAY_I(ihw),
        .I_RELOAD_I(irl), .I_RELOAD_SET_I(irs), .I_INVAL_I(iv), .I_INVAL_SET_I(ivs),
        .I_INVAL_WAY_I(ivw), .OBS_SET_I(os), .D_OBS_VALID_O(dvo), .D_OBS_TREE_O(dto),
        .I_OBS_VALID_O(ivo), .I_OBS_TREE_O(ito));
    function automatic logic [2:0] vic(logic [7:0] v, logic [6:0] t, bit ign);
        if (!ign) for (int k = 0; k < 8; k++) if (!v[k]) return k[2:0];
        vic[2] = t[0];
        vic[1] = t[1 + vic[2]];
        vic[0] = t[3 + vic[2:1]];
    endfunction
    function automatic logic [6:0] upd(logic [6:0] t, logic [2:0] w, bit l);
        t[0] = ~w[2] ^ l;
        t[w[2] ? 2 : 1] = ~w[1] ^ l;
        t[3 + w[2:1]] = ~w[0] ^ l;
        return t;
    endfunction
    function automatic logic [6:0] sf(logic [1:0] b);
        return (b == 2'h3) ? 7'h7f : {5'h00, b};
    endfunction
    task automatic chk(logic [29:0] a, logic [29:0] e);
        checks_done++;
        if (a !== e) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h exp %h", $time, a, e);
        end
    endtask
    task automatic clr(int c);
        for (int s = 0; s < 128; s++) begin
            mv[c][s] = 8'h00;
            mt[c][s] = 7'h00;
        end
    endtask
    task automatic step();
        logic [2:0] dw, iw;
        dw = vic(mv[0][rs], mt[0][rs], p_as);
        iw = vic(mv[1][ims], mt[1][ims], 1'b0);
        chk(dwo, dw);
        chk(iwo, iw);
        chk({dvo, dto, ivo, ito}, eo);
        eo = {mv[0][os], mt[0][os], mv[1][os], mt[1][os]};
        if (dfi) clr(0);
        else begin
            if (dh) mt[0][dhs] = upd(mt[0][dhs], dhw, dhl);
            if (dv && !(rl && dvs == rs)) mv[0][dvs][dvw] = 1'b0;
            if (rl) mv[0][rs][dw] = 1'b1;
            if (rl) mt[0][rs] = upd(mt[0][rs], dw, drll);
        end
        if (ifi) clr(1);
        else begin
            if (ih) mt[1][ihs] = upd(mt[1][ihs], ihw, 1'b0);
            if (iv && !(irl && ivs == irs)) mv[1][ivs][ivw] = 1'b0;
            if (irl) mv[1][irs][ilw] = 1'b1;
            if (irl) mt[1][irs] = upd(mt[1][irs], ilw, 1'b0);
            if (im) ilw = iw;
        end
        r = $urandom;
        q = $urandom;
        dh <= r[0]; dhl <= r[1]; dhs <= sf(r[3:2]); dhw <= r[6:4];
        drl <= r[7] & !p_as & !go; drll <= r[8]; drs <= sf(r[10:9]);
        dv <= r[11] & r[12]; dvs <= sf(r[14:13]); dvw <= r[17:15];
        ih <= r[18]; ihs <= sf(r[20:19]); ihw <= r[23:21];
        iv <= r[24] & r[25]; ivs <= sf(r[27:26]); ivw <= r[30:28];
        ifi <= q[5:0] == 0; im <= q[6] & (q[5:0] != 0); ims <= sf(q[8:7]);
        irl <= !q[6] & q[9]; irs <= sf(q[11:10]); dfi <= q[17:12] == 0;
        go <= q[21:18] == 0 & !p_as & !go; gs <= sf(q[23:22]); os <= sf(q[25:24]);
    endtask
    task automatic results();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        r = $urandom(49609);
        clr(0);
        clr(1);
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int n = 0; n < 3000; n++) begin
            @(posedge clk);
            step();
        end
        results();
    end
endmodule // lcplru_top_bench
